// ---- rtl/laf_acq.v ----
// Acquisition slice for one pod pair with thresholds, test and registers
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "laf_map.vh"
module laf_acq #(
  parameter POD_BASE = 0,
  parameter NCH      = 34
) (
  input  wire            clock,
  input  wire            rst,
  input  wire [16:0]     pod_a,
  input  wire [16:0]     pod_b,
  input  wire [3:0]      st_clk,
  input  wire            is_master,
  input  wire            ext_tick,
  input  wire            phase_sync,
  input  wire [7:0]      addr,
  input  wire [31:0]     wdata,
  input  wire            wr,
  input  wire            rd,
  output reg  [31:0]     rdata,
  output reg             irq,
  output reg  [63:0]     thresh,
  output reg             test_ser,
  output reg             div_tick_out,
  output reg  [NCH-1:0]  sample,
  output reg             sample_vld
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  wire [NCH-1:0] pin_s;
  wire [3:0]     stc_s;
  wire           tick_s, psync_s;

  laf_sync #(.W(NCH)) u_sync_pod (
    .clock (clock),
    .rst   (rst),
    .d     ({pod_b, pod_a}),
    .q     (pin_s)
  );

  laf_sync #(.W(6)) u_sync_clk (
    .clock (clock),
    .rst   (rst),
    .d     ({phase_sync, ext_tick, st_clk}),
    .q     ({psync_s, tick_s, stc_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [5:0]     ctrl_r, fail_ch_r;
  reg [1:0]     clksel_r;
  reg [15:0]    rate_div_r, test_pat_r;
  reg [31:0]    range_lo_r, range_hi_r;
  reg [2:0]     int_stat_r, int_en_r, delay_r;
  reg           fail_r, run_d_r;
  wire wr_ctrl = wr && (addr == `LAF_CTRL);
  wire run_go  = ctrl_r[`LAF_CTRL_RUN] && !run_d_r;
  wire timing  = ctrl_r[`LAF_CTRL_TIMING];
  wire test_on = ctrl_r[`LAF_CTRL_TEST];
  // Control and configuration writes
  always @(posedge clock) begin
    if (rst) begin
      ctrl_r     <= 6'h00;
      clksel_r   <= 2'h0;
      rate_div_r <= 16'h0000;
      range_lo_r <= 32'h00000000;
      range_hi_r <= 32'hffffffff;
      run_d_r    <= 1'b0;
    end else begin
      run_d_r <= ctrl_r[`LAF_CTRL_RUN];
      if (wr_ctrl) ctrl_r <= wdata[5:0];
      if (wr && addr == `LAF_CLKSEL) clksel_r <= wdata[1:0];
      if (wr && addr == `LAF_RATE_DIV) rate_div_r <= wdata[15:0];
      if (wr && addr == `LAF_RANGE_LO) range_lo_r <= wdata;
      if (wr && addr == `LAF_RANGE_HI) range_hi_r <= wdata;
    end
  end

  // Per-pod threshold channels; one write touches one pod only
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_thr
      always @(posedge clock) begin
        if (rst)
          thresh[g*8 +: 8] <= `LAF_THRESH_RST;
        else if (wr && addr == (`LAF_THRESH0 + g*4))
          thresh[g*8 +: 8] <= wdata[7:0];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Test pattern source and comparator echo
  // Pattern rotates every cycle while test is on
  always @(posedge clock) begin
    if (rst) begin
      test_pat_r <= `LAF_PAT_RST;
      test_ser   <= 1'b0;
    end else begin
      if (wr && addr == `LAF_TEST_PAT)
        test_pat_r <= wdata[15:0];
      else if (test_on)
        test_pat_r <= {test_pat_r[14:0], test_pat_r[15]};
      test_ser <= test_on && test_pat_r[15];
    end
  end

  // In test the slices replace probe data by the serial bit
  wire [NCH-1:0] ch = test_on ? {NCH{test_ser}} : pin_s;

  ////////////////////////////////////////////////////////////////////////////
  // Delay taps for clock placement
  reg [NCH-1:0] dl_r [0:`LAF_TAPS-1];
  reg [`LAF_TAPS-1:0] tdl_r;
  integer i;
  // Tap 0 is newest; larger taps take older data and move the sample point earlier
  always @(posedge clock) begin
    if (rst) begin
      for (i = 0; i < `LAF_TAPS; i = i + 1) dl_r[i] <= {NCH{1'b0}};
      tdl_r <= {`LAF_TAPS{1'b0}};
    end else begin
      dl_r[0] <= ch;
      for (i = 1; i < `LAF_TAPS; i = i + 1) dl_r[i] <= dl_r[i-1];
      tdl_r <= {tdl_r[`LAF_TAPS-2:0], test_ser};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample event generation
  reg         stc_d_r;
  reg [15:0]  div_cnt_r;
  reg [1:0]   phase_r;
  wire        stc_sel = stc_s[clksel_r];
  wire        st_edge = stc_sel && !stc_d_r;
  wire        fast    = (rate_div_r == 16'h0000);
  wire        div_hit = (div_cnt_r == rate_div_r);
  reg         tick;

  // Four-phase counter realigned by the shared sync
  always @(posedge clock) begin
    if (rst) begin
      stc_d_r      <= 1'b0;
      div_cnt_r    <= 16'h0000;
      phase_r      <= 2'h0;
      div_tick_out <= 1'b0;
    end else begin
      stc_d_r <= stc_sel;
      if (psync_s) phase_r <= 2'h0;
      else phase_r <= phase_r + 2'h1;
      if (div_hit || psync_s) div_cnt_r <= 16'h0000;
      else div_cnt_r <= div_cnt_r + 16'h0001;
      div_tick_out <= is_master && timing && !fast && div_hit;
    end
  end
  // Fast rates sample on the reference, slow ones on the own divider in the master and on the shared tick elsewhere
  always @* begin
    if (!timing) tick = st_edge;
    else if (fast) tick = 1'b1;
    else if (is_master) tick = div_hit;
    else tick = tick_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock/data masking
  wire clku_a = ctrl_r[`LAF_CTRL_CLKU0] && (POD_BASE < `LAF_CLK_PODS);
  wire clku_b = ctrl_r[`LAF_CTRL_CLKU1] &&
                (POD_BASE + 1 < `LAF_CLK_PODS);
  wire mask_a = clku_a && !timing;
  wire mask_b = clku_b && !timing;
  wire [NCH-1:0] keep = {~mask_b, {16{1'b1}}, ~mask_a, {16{1'b1}}};
  wire [NCH-1:0] tap  = dl_r[delay_r] & keep;
  wire [NCH-1:0] expv = {NCH{tdl_r[delay_r]}} & keep;

  // Lowest channel that differs from expectation
  function [5:0] first_bad;
    input [NCH-1:0] v;
    integer k;
    begin
      first_bad = 6'h3f;
      for (k = NCH - 1; k >= 0; k = k - 1)
        if (v[k]) first_bad = k[5:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Run sequencer: optimise then store
  localparam ST_IDLE  = 3'b001;
  localparam ST_OPT   = 3'b010;
  localparam ST_STORE = 3'b100;

  reg [2:0] state_r, opt_tap_r, best_tap_r;
  reg [7:0] opt_ev_r, opt_err_r, best_err_r;
  reg       opt_done_ev;

  wire       unstable = |(dl_r[opt_tap_r] ^ dl_r[opt_tap_r + 3'h1]);
  wire [7:0] err_now  = opt_err_r + {7'h00, unstable};
  wire       tap_end  = tick && (opt_ev_r == `LAF_OPT_EVENTS - 8'h01);

  // Sweep taps, score data transitions near each one
  always @(posedge clock) begin
    if (rst) begin
      state_r     <= ST_IDLE;
      opt_tap_r   <= 3'h0;
      opt_ev_r    <= 8'h00;
      opt_err_r   <= 8'h00;
      best_err_r  <= 8'hff;
      best_tap_r  <= 3'h0;
      delay_r     <= 3'h0;
      opt_done_ev <= 1'b0;
    end else begin
      opt_done_ev <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (run_go) begin
            state_r    <= ST_OPT;
            opt_tap_r  <= 3'h0;
            opt_ev_r   <= 8'h00;
            opt_err_r  <= 8'h00;
            best_err_r <= 8'hff;
          end
        end
        ST_OPT: begin
          if (!ctrl_r[`LAF_CTRL_RUN]) begin
            state_r <= ST_IDLE;
          end else if (tap_end) begin
            opt_ev_r  <= 8'h00;
            opt_err_r <= 8'h00;
            if (err_now < best_err_r) begin
              best_err_r <= err_now;
              best_tap_r <= opt_tap_r;
            end
            if (opt_tap_r == `LAF_TAPS - 2) begin
              state_r     <= ST_STORE;
              delay_r     <= (err_now < best_err_r) ? opt_tap_r
                                                    : best_tap_r;
              opt_done_ev <= 1'b1;
            end else begin
              opt_tap_r <= opt_tap_r + 3'h1;
            end
          end else if (tick) begin
            opt_ev_r  <= opt_ev_r + 8'h01;
            opt_err_r <= err_now;
          end
        end
        ST_STORE: begin
          if (!ctrl_r[`LAF_CTRL_RUN]) state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture, range term and read-back check
  // Wide range only joins this slice's own aligned pair
  wire [31:0] rval  = ctrl_r[`LAF_CTRL_PAIR] ? {tap[32:17], tap[15:0]}
                                             : {16'h0000, tap[15:0]};
  wire        in_rng = (rval >= range_lo_r) && (rval <= range_hi_r);
  wire        store  = (state_r == ST_STORE) && tick;
  wire        bad    = store && test_on && (tap != expv);
  wire [2:0]  ev     = {store && in_rng, bad, opt_done_ev};
  wire        fail_clr = wr && addr == `LAF_INT_CLR && wdata[`LAF_INT_FAIL];

  // Sample word and storage strobe
  always @(posedge clock) begin
    if (rst) begin
      sample     <= {NCH{1'b0}};
      sample_vld <= 1'b0;
    end else begin
      sample_vld <= store;
      if (store) sample <= tap;
    end
  end

  // First failing channel is held until software clears the flag
  always @(posedge clock) begin
    if (rst) begin
      fail_r    <= 1'b0;
      fail_ch_r <= 6'h00;
    end else if (bad && (!fail_r || fail_clr)) begin
      fail_r    <= 1'b1;
      fail_ch_r <= first_bad(tap ^ expv);
    end else if (fail_clr) begin
      fail_r <= 1'b0;
    end
  end

  // Sticky events; a new event beats a clear in the same cycle
  always @(posedge clock) begin
    if (rst) begin
      int_stat_r <= 3'h0;
      int_en_r   <= 3'h0;
      irq        <= 1'b0;
    end else begin
      if (wr && addr == `LAF_INT_EN) int_en_r <= wdata[2:0];
      if (wr && addr == `LAF_INT_CLR)
        int_stat_r <= (int_stat_r & ~wdata[2:0]) | ev;
      else
        int_stat_r <= int_stat_r | ev;
      irq <= |(int_stat_r & int_en_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux, data valid the cycle after the strobe
  always @(posedge clock) begin
    if (rst) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      if (addr >= `LAF_THRESH0 && addr <= `LAF_THRESH7 && addr[1:0] == 2'h0)
        rdata <= {24'h000000, thresh[(addr[4:2])*8 +: 8]};
      else
        case (addr)
          `LAF_CTRL:     rdata <= {26'h0, ctrl_r};
          `LAF_CLKSEL:   rdata <= {30'h0, clksel_r};
          `LAF_RATE_DIV: rdata <= {16'h0, rate_div_r};
          `LAF_RANGE_LO: rdata <= range_lo_r;
          `LAF_RANGE_HI: rdata <= range_hi_r;
          `LAF_TEST_PAT: rdata <= {16'h0, test_pat_r};
          `LAF_STATUS:   rdata <= {27'h0, phase_r, fail_r, state_r[2],
                                   state_r[1]};
          `LAF_FAIL_CH:  rdata <= {26'h0, fail_ch_r};
          `LAF_INT_STAT: rdata <= {29'h0, int_stat_r};
          `LAF_INT_EN:   rdata <= {29'h0, int_en_r};
          `LAF_SAMPLE:   rdata <= sample[31:0];
          `LAF_DELAY:    rdata <= {29'h0, delay_r};
          default:       rdata <= 32'h00000000;
        endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end

endmodule

// ---- rtl/laf_map.vh ----
// Register offsets, field positions, reset values and timing counts
// What this block does
// - Each pod brings sixteen data channels plus one clock/data channel.
// - Clock/data channel is data unless used as state clock in state mode.
// - Only four clock/data channels may ever act as clock sources.
// - One threshold per pod covers its data and clock channels alike.
// - Eight separate threshold settings, one per pod, written independently.
// - Comparator slice drives the serial test bit onto all its channels.
// - One acquisition slice handles 34 channels of one pod pair.
// - All four state clocks reach every slice; it makes its own sample clock.
// - Every run starts with clock optimization before any data is stored.
// - Optimization picks the delay tap where data is stable at sampling.
// - Fast timing rates take the sample period from the reference clock.
// - For slow rates one designated slice divides and shares the clock.
// - A shared phase sync keeps all slices' internal clocking in step.
// - Test patterns cross all channels and are read back and checked.
// - Wide range terms use only an aligned pod pair, never a straddle.
`ifndef LAF_MAP_VH
`define LAF_MAP_VH

// Register byte offsets
`define LAF_CTRL      8'h00
`define LAF_CLKSEL    8'h04
`define LAF_RATE_DIV  8'h08
`define LAF_RANGE_LO  8'h0c
`define LAF_RANGE_HI  8'h10
`define LAF_TEST_PAT  8'h14
`define LAF_STATUS    8'h18
`define LAF_FAIL_CH   8'h1c
`define LAF_INT_STAT  8'h20
`define LAF_INT_EN    8'h24
`define LAF_INT_CLR   8'h28
`define LAF_SAMPLE    8'h2c
`define LAF_DELAY     8'h30
`define LAF_THRESH0   8'h40
`define LAF_THRESH7   8'h5c

// Control fields
`define LAF_CTRL_RUN    0
`define LAF_CTRL_TIMING 1
`define LAF_CTRL_TEST   2
`define LAF_CTRL_PAIR   3
`define LAF_CTRL_CLKU0  4
`define LAF_CTRL_CLKU1  5

// Interrupt bits
`define LAF_INT_OPT   0
`define LAF_INT_FAIL  1
`define LAF_INT_RANGE 2

// Reset values
`define LAF_THRESH_RST 8'h80
`define LAF_PAT_RST    16'ha5c3

// Timing counts
`define LAF_OPT_EVENTS 8'h04
`define LAF_TAPS       8
`define LAF_CLK_PODS   4

`endif

// ---- rtl/laf_sync.v ----
// Two-flop synchroniser for a bus of independent levels
`timescale 1ns/1ps
module laf_sync #(
  parameter W = 1
) (
  input  wire         clock,
  input  wire         rst,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;

  // First flop feeds only the second one
  always @(posedge clock) begin
    if (rst) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end

  assign q = s2_r;
endmodule

// ---- tb/laf_target.sv ----
// Target system model that drives the probe pods and the state clocks
`timescale 1ns/1ps
module laf_target (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [16:0] va,
  input  wire logic [16:0] vb,
  input  wire logic [7:0]  half,
  output      logic [16:0] pod_a,
  output      logic [16:0] pod_b,
  output      logic [3:0]  st_clk
);
  logic [7:0] cnt_r;
  logic       ph_r;
  //////////////////////////////////////////////////////////////////////////
  // State clocks stand still while half is zero, so no stray edge can
  // reach the slice between bursts of target activity
  always @(posedge clock) begin
    if (rst || half == 8'h00) begin
      cnt_r <= 8'h00;
      ph_r  <= 1'b0;
    end else if (cnt_r == half) begin
      cnt_r <= 8'h00;
      ph_r  <= ~ph_r;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  // Data is held steady across each clock edge, as the target guarantees
  assign st_clk = {4{ph_r}};
  assign pod_a  = va;
  assign pod_b  = vb;
endmodule

// ---- tb/laf_acq_properties.sv ----
// Port-level checker for the acquisition slice
`timescale 1ns/1ps
module laf_acq_properties #(
  parameter POD_BASE = 0,
  parameter NCH      = 34
) (
  input wire logic           clock,
  input wire logic           rst,
  input wire logic [16:0]    pod_a,
  input wire logic [16:0]    pod_b,
  input wire logic [3:0]     st_clk,
  input wire logic           is_master,
  input wire logic           ext_tick,
  input wire logic           phase_sync,
  input wire logic [7:0]     addr,
  input wire logic [31:0]    wdata,
  input wire logic           wr,
  input wire logic           rd,
  input wire logic [31:0]    rdata,
  input wire logic           irq,
  input wire logic [63:0]    thresh,
  input wire logic           test_ser,
  input wire logic           div_tick_out,
  input wire logic [NCH-1:0] sample,
  input wire logic           sample_vld
);
  logic        run_q;
  logic        test_q;
  logic        cu_q;
  logic [31:0] wd_q;
  //////////////////////////////////////////////////////////////////////////
  // Shadow of control writes; the control word shows at the ports only through a register read
  always @(posedge clock) begin
    if (rst) begin
      run_q  <= 1'b0;
      test_q <= 1'b0;
      cu_q   <= 1'b0;
    end else if (wr && addr == 8'h00) begin
      run_q  <= wdata[0];
      test_q <= wdata[2];
      cu_q   <= wdata[0] && wdata[4] && !wdata[1];
    end
  end
  // Write data bus of the previous cycle, for checks one cycle after the write
  always @(posedge clock) begin
    wd_q <= wdata;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_run_go;
    wr && addr == 8'h00 && wdata[0] && !run_q;
  endsequence
  sequence s_quiet;
    !sample_vld [*8];
  endsequence
  //////////////////////////////////////////////////////////////////////////
  a_run_opt_first: assert property (s_run_go |=> s_quiet)
    else $error("sample stored before clock optimisation");
  a_thresh_own: assert property (wr && addr == 8'h4c |=>
    thresh[31:24] == wd_q[7:0] && $stable(thresh[23:0])
    && $stable(thresh[63:32]))
    else $error("threshold write wrong or spilled");
  a_thresh_read: assert property (rd && addr == 8'h40 |=>
    rdata[7:0] == thresh[7:0])
    else $error("threshold read back wrong");
  a_idle_read: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data present without a read");
  a_hole_read: assert property (rd && (addr == 8'h3c || addr == 8'h41)
    |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  a_irq_mask: assert property (wr && addr == 8'h24 && wdata[2:0] == 3'h0
    |=> ##1 !irq)
    else $error("masked interrupt still high");
  a_div_single: assert property (div_tick_out |=> !div_tick_out)
    else $error("divided tick longer than one cycle");
  a_div_master: assert property (!is_master [*3] |-> !div_tick_out)
    else $error("non-master slice drives divided tick");
  a_sample_hold: assert property (!sample_vld |-> $stable(sample))
    else $error("sample changed without store");
  a_test_quiet: assert property (!test_q [*2] |-> !test_ser)
    else $error("test bit active with test off");
  a_clk_chan: assert property ((POD_BASE < 4) && cu_q && $past(cu_q)
    && sample_vld |-> !sample[16])
    else $error("clock channel stored as data");
endmodule
bind laf_acq laf_acq_properties #(
  .POD_BASE (POD_BASE),
  .NCH      (NCH)
) u_props (
  .clock, .rst, .pod_a, .pod_b, .st_clk, .is_master, .ext_tick,
  .phase_sync, .addr, .wdata, .wr, .rd, .rdata, .irq, .thresh,
  .test_ser, .div_tick_out, .sample, .sample_vld
);

// ---- tb/logic_acquisition_frontend_tb_top.sv ----
// Self-checking bench for the acquisition slice
`timescale 1ns/1ps
module logic_acquisition_frontend_tb_top;
  logic        clock, rst, is_master, phase_sync, wr, rd;
  logic        irq, test_ser, div_tick_out, sample_vld;
  logic [7:0]  addr, half;
  logic [31:0] wdata, rdata, v;
  logic [16:0] va, vb, pod_a, pod_b;
  logic [3:0]  st_clk;
  logic [63:0] thresh, et;
  logic [33:0] sample;
  int          miscompares, samples_checked, cyc, n, k;
  // The slice is master from the slow-rate part onward, and its divided tick feeds straight back
  laf_acq #(.POD_BASE (0), .NCH (34)) dut (
    .clock, .rst, .pod_a, .pod_b, .st_clk, .is_master,
    .ext_tick (div_tick_out), .phase_sync, .addr, .wdata, .wr, .rd,
    .rdata, .irq, .thresh, .test_ser, .div_tick_out, .sample, .sample_vld
  );
  laf_target u_tgt (.clock, .rst, .va, .vb, .half, .pod_a, .pod_b, .st_clk);
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [63:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // Looks 1 ns after the calling edge, so a strobe ending there is settled
  task automatic wait_vld(output int c);
    c = 0;
    #1;
    while (sample_vld !== 1'b1 && c < 300) begin
      @(posedge clock);
      #1;
      c++;
    end
    chk("vld_wait", 64'(c < 300), 64'h1);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0;
    is_master = 1'b0; phase_sync = 1'b0; half = 8'h00;
    va = 17'h1a5c3; vb = 17'h10f0f;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    // Reset values and an unmapped hole
    chk("thresh_rst", thresh, {8{8'h80}});
    rreg(8'h14, v); chk("pat_rst", v, 32'ha5c3);
    rreg(8'h10, v); chk("range_hi_rst", v, 32'hffffffff);
    rreg(8'h3c, v); chk("hole", v, 32'h0);
    rreg(8'h20, v); chk("int_rst", v, 32'h0);
    // Each pod's level lands in its own byte only
    et = {8{8'h80}};
    for (k = 0; k < 8; k++) begin
      et[8*k +: 8] = 8'h31 + 8'(k);
      wreg(8'h40 + 8'(4 * k), {24'h0, et[8*k +: 8]});
      @(posedge clock);
      #1;
      chk("thresh", thresh, et);
    end
    rreg(8'h40, v); chk("thresh_rd", v, 32'h31);
    // Fast timing run: optimise first, then store every cycle
    wreg(8'h24, 32'h7);
    wreg(8'h00, 32'h3);
    wait_vld(n);
    chk("opt_wait", 64'(n >= 28), 64'h1);
    chk("sample", sample, {vb, va});
    @(posedge clock);
    #1;
    chk("fast_rate", sample_vld, 1'b1);
    rreg(8'h18, v); chk("storing", v[2:0], 3'b010);
    rreg(8'h30, v); chk("delay_tap", v, 32'h0);
    rreg(8'h20, v); chk("int_stat", v[2:0], 3'b101);
    chk("irq_on", irq, 1'b1);
    wreg(8'h24, 32'h0);
    @(posedge clock);
    #1;
    chk("irq_masked", irq, 1'b0);
    wreg(8'h00, 32'h0);
    wreg(8'h28, 32'h7);
    rreg(8'h20, v); chk("int_clr", v, 32'h0);
    wreg(8'h24, 32'h7);
    // Paired range: one above the value misses, the value itself hits
    for (k = 0; k < 2; k++) begin
      wreg(8'h00, 32'h0);
      wreg(8'h28, 32'h7);
      wreg(8'h0c, {vb[15:0], va[15:0]} + 32'(1 - k));
      wreg(8'h00, 32'hb);
      wait_vld(n);
      rreg(8'h20, v); chk("range_pair", v[2], k[0]);
    end
    // Slow rate divided by the master, then realigned by phase sync
    wreg(8'h00, 32'h0);
    wreg(8'h08, 32'h3);
    is_master <= 1'b1;
    wreg(8'h00, 32'h3);
    for (k = 0; k < 2; k++) begin
      wait_vld(n);
      @(posedge clock);
      #1;
      wait_vld(n);
      chk("slow_period", n, 3);
      @(posedge clock);
      phase_sync <= 1'b1;
      @(posedge clock);
      phase_sync <= 1'b0;
    end
    // Test pattern replaces probe data; a good pipeline raises no failure
    wreg(8'h00, 32'h0);
    wreg(8'h08, 32'h0);
    wreg(8'h00, 32'h7);
    wait_vld(n);
    n = 0;
    repeat (32) begin
      @(posedge clock);
      #1;
      n += int'(test_ser === 1'b1);
    end
    chk("test_ones", n, 16);
    rreg(8'h18, v); chk("no_fail", v[2], 1'b0);
    // State mode: pod A clock channel serves as clock, pod B's stays data
    wreg(8'h00, 32'h0);
    wreg(8'h04, 32'h2);
    half <= 8'h01;
    wreg(8'h00, 32'h11);
    wait_vld(n);
    chk("clk_chan", sample[16], 1'b0);
    chk("data_chan", sample[33], vb[16]);
    chk("state_data", sample[15:0], va[15:0]);
    half <= 8'h00;
    summarize();
  end
endmodule
